// file: logic/rsd_defines.svh
// constants for the reference self-check block
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH
`define RSD_ADDR_CONV_CONFIG 8'h08
`define RSD_ADDR_FAULT_ANALYSIS 8'h0E
`define RSD_FAULT_ANALYSIS_RESET 16'h0000
`define RSD_RESULT_RESET 16'h0000
`define RSD_CODE_LSB 4
`define RSD_NIBBLE_ZERO 4'h0
`define RSD_OSC_WINDOW 8'hFF
`define RSD_OSC_LIMIT 4'h4
`define RSD_CNT_ONE 8'h01
`define RSD_TOG_ONE 4'h1
`define RSD_CNT_ZERO 8'h00
`define RSD_TOG_ZERO 4'h0
`define RSD_REG_WIDTH 16
`define RSD_ALERT_BIT 0
`endif

// file: logic/rsd_pkg.sv
// types for the reference self-check block
package rsd_pkg;
  typedef enum logic [1:0] {
    RSD_IDLE = 2'b00,
    RSD_CELLS = 2'b01,
    RSD_CHECK = 2'b10,
    RSD_AUX = 2'b11
  } rsd_state_t;
endpackage

// file: logic/rsd_osc_detect.sv
// oscillation detector on the reference comparator input
`timescale 1ns/1ps
`include "rsd_defines.svh"
module rsd_osc_detect (
  input wire logic clk,
  input wire logic rstN,
  input wire logic refHigh,
  output logic oscSeen
);
  logic [7:0] windowCnt;
  logic [7:0] next_windowCnt;
  logic [3:0] toggles;
  logic [3:0] next_toggles;
  logic lastLevel;
  logic next_lastLevel;
  logic next_oscSeen;

  // count level changes within a fixed window
  always_comb begin
    next_lastLevel = refHigh;
    next_windowCnt = windowCnt + `RSD_CNT_ONE;
    next_toggles = toggles;
    next_oscSeen = 1'b0;
    if (refHigh != lastLevel && toggles != `RSD_OSC_LIMIT) begin
      next_toggles = toggles + `RSD_TOG_ONE;
    end
    if (toggles == `RSD_OSC_LIMIT) begin
      next_oscSeen = 1'b1;
    end
    if (windowCnt == `RSD_OSC_WINDOW) begin
      next_toggles = `RSD_TOG_ZERO;
    end
  end

  // register the detector state
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      windowCnt <= `RSD_CNT_ZERO;
      toggles <= `RSD_TOG_ZERO;
      lastLevel <= 1'b0;
      oscSeen <= 1'b0;
    end else begin
      windowCnt <= next_windowCnt;
      toggles <= next_toggles;
      lastLevel <= next_lastLevel;
      oscSeen <= next_oscSeen;
    end
  end
endmodule // rsd_osc_detect

// file: logic/rsd_self_check.sv
// scan sequencing, self-check result capture and reference-open alert
// Function
// - self-check conversion runs only when enable bit in config register 0x08 set
// - self-check starts right after last cell conversion, before auxiliary conversions
// - 12-bit code sits in upper three nibbles; lowest nibble holds zero
// - conversion full scale is thermistor supply; code is half ref over supply
// - oscillating reference pin sets reference-open alert in fault-analysis register
// - fault-analysis register at 0x0E, resets to 0x0000
`timescale 1ns/1ps
`include "rsd_defines.svh"
module rsd_self_check (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic selfCheckEnable,
  input wire logic auxEnable,
  input wire logic scanStart,
  input wire logic cellsDone,
  input wire logic convDone,
  input wire logic [11:0] convCode,
  input wire logic auxDone,
  input wire logic refPinHigh,
  input wire logic alertClear,
  output logic convStart,
  output logic useThermistorScale,
  output logic auxStart,
  output logic scanBusy,
  output logic [15:0] selfCheckResult,
  output logic [15:0] faultAnalysisReg,
  output logic referenceOpenAlert
);
  // ----------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------
  // reset release and reference pin path
  logic rstMeta;
  logic rstN;
  logic refMeta;
  logic refSync;
  logic oscSeen;

  // scan sequencer
  rsd_pkg::rsd_state_t state;
  rsd_pkg::rsd_state_t next_state;
  logic next_convStart;
  logic next_useThermistorScale;
  logic next_auxStart;
  logic next_scanBusy;
  logic [15:0] next_selfCheckResult;

  // reference-open alert and its register image
  logic next_referenceOpenAlert;
  logic [15:0] next_faultAnalysisReg;

  // ----------------------------------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------------------------------
  // two flops keep the reset release off the async edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // reference pin comparator into clock domain
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      refMeta <= 1'b0;
      refSync <= 1'b0;
    end else begin
      refMeta <= refPinHigh;
      refSync <= refMeta;
    end
  end

  // ----------------------------------------------------------------
  // reference pin oscillation detector
  // ----------------------------------------------------------------
  // a floating reference pin shows up as level flicker
  // watches only the synchronised level
  rsd_osc_detect uOsc (
    .clk(clk),
    .rstN(rstN),
    .refHigh(refSync),
    .oscSeen(oscSeen)
  );

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  // next state and outputs of the scan sequence
  always_comb begin
    // hold by default; start requests last one cycle
    next_state = state;
    next_convStart = 1'b0;
    next_useThermistorScale = useThermistorScale;
    next_auxStart = 1'b0;
    next_selfCheckResult = selfCheckResult;
    case (state)
      // waiting for a scan request; scale back on regulator reference
      rsd_pkg::RSD_IDLE: begin
        next_useThermistorScale = 1'b0;
        if (scanStart) begin
          next_state = rsd_pkg::RSD_CELLS;
        end
      end

      // cells converting; enable is read as the last cell finishes
      rsd_pkg::RSD_CELLS: begin
        if (cellsDone) begin
          if (selfCheckEnable) begin
            // self-check goes ahead of any auxiliary channel
            next_state = rsd_pkg::RSD_CHECK;
            next_convStart = 1'b1;
            next_useThermistorScale = 1'b1;
          end else if (auxEnable) begin
            // disabled check: result register left as it was
            next_state = rsd_pkg::RSD_AUX;
            next_auxStart = 1'b1;
          end else begin
            next_state = rsd_pkg::RSD_IDLE;
          end
        end
      end

      // self-check conversion running on the thermistor supply scale
      rsd_pkg::RSD_CHECK: begin
        if (convDone) begin
          // code into the upper nibbles, low nibble forced to zero
          next_selfCheckResult = {convCode, `RSD_NIBBLE_ZERO};
          next_useThermistorScale = 1'b0;
          if (auxEnable) begin
            next_state = rsd_pkg::RSD_AUX;
            next_auxStart = 1'b1;
          end else begin
            next_state = rsd_pkg::RSD_IDLE;
          end
        end
      end

      // auxiliary channels converting; their end closes the scan
      rsd_pkg::RSD_AUX: begin
        if (auxDone) begin
          next_state = rsd_pkg::RSD_IDLE;
        end
      end

      // no other code is reachable; recover to idle
      default: begin
        next_state = rsd_pkg::RSD_IDLE;
      end
    endcase
    // busy follows the next state so it drops together with idle
    next_scanBusy = (next_state != rsd_pkg::RSD_IDLE);
  end

  // ----------------------------------------------------------------
  // reference-open alert
  // ----------------------------------------------------------------
  // set wins over clear, so an event in the clearing cycle is kept
  always_comb begin
    next_referenceOpenAlert = referenceOpenAlert;
    if (alertClear) begin
      next_referenceOpenAlert = 1'b0;
    end
    if (oscSeen) begin
      next_referenceOpenAlert = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // fault-analysis register image
  // ----------------------------------------------------------------
  // alert bit at its field, every other bit reads as zero
  // upper bits reserved for other fault-analysis fields
  for (genvar b = 0; b < `RSD_REG_WIDTH; b = b + 1) begin : gFaultBit
    if (b == `RSD_ALERT_BIT) begin : gAlert
      assign next_faultAnalysisReg[b] = next_referenceOpenAlert;
    end else begin : gZero
      assign next_faultAnalysisReg[b] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register stage
  // ----------------------------------------------------------------
  // register the sequencer state and its outputs
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state <= rsd_pkg::RSD_IDLE;
      convStart <= 1'b0;
      useThermistorScale <= 1'b0;
      auxStart <= 1'b0;
      scanBusy <= 1'b0;
      selfCheckResult <= `RSD_RESULT_RESET;
    end else begin
      state <= next_state;
      convStart <= next_convStart;
      useThermistorScale <= next_useThermistorScale;
      auxStart <= next_auxStart;
      scanBusy <= next_scanBusy;
      selfCheckResult <= next_selfCheckResult;
    end
  end

  // register the alert and the fault-analysis image together
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      referenceOpenAlert <= 1'b0;
      faultAnalysisReg <= `RSD_FAULT_ANALYSIS_RESET;
    end else begin
      referenceOpenAlert <= next_referenceOpenAlert;
      faultAnalysisReg <= next_faultAnalysisReg;
    end
  end
endmodule // rsd_self_check

// file: tb/rsd_self_check_asserts.sv
// port-level checker for the reference self-check block
`timescale 1ns/1ps
module rsd_self_check_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic selfCheckEnable,
  input wire logic auxEnable,
  input wire logic cellsDone,
  input wire logic convDone,
  input wire logic [11:0] convCode,
  input wire logic alertClear,
  input wire logic convStart,
  input wire logic useThermistorScale,
  input wire logic auxStart,
  input wire logic [15:0] selfCheckResult,
  input wire logic [15:0] faultAnalysisReg,
  input wire logic referenceOpenAlert
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_conv_cause: assert property (convStart |-> $past(cellsDone && selfCheckEnable))
    else $error("self-check start without cause");
  chk_off_quiet: assert property (cellsDone && !selfCheckEnable |=> !convStart)
    else $error("self-check started while disabled");
  chk_aux_cause: assert property (auxStart |-> $past(auxEnable && (convDone || cellsDone && !selfCheckEnable)))
    else $error("aux start out of order");
  chk_scale_on: assert property (convStart |-> useThermistorScale)
    else $error("scale not thermistor at start");
  chk_scale_rise: assert property ($rose(useThermistorScale) |-> convStart)
    else $error("scale raised without start");
  chk_result_load: assert property (convDone && useThermistorScale |=> selfCheckResult == {$past(convCode), 4'h0})
    else $error("result not loaded");
  chk_result_hold: assert property (!$past(convDone) |-> $stable(selfCheckResult))
    else $error("result changed without conversion");
  chk_nibble_zero: assert property (selfCheckResult[3:0] == 4'h0)
    else $error("low nibble not zero");
  chk_alert_map: assert property (faultAnalysisReg == {15'h0, referenceOpenAlert})
    else $error("fault register mismatch");
  chk_alert_sticky: assert property (referenceOpenAlert && !alertClear |=> referenceOpenAlert)
    else $error("alert dropped");
  cover property (convStart);
  cover property (auxStart);
  cover property ($rose(referenceOpenAlert));
endmodule // rsd_self_check_asserts

// file: tb/rsd_conv_model.sv
// converter model answering start pulses after a chosen latency
`timescale 1ns/1ps
module rsd_conv_model (
  input wire logic clk,
  input wire logic convStart,
  input wire logic auxStart,
  input wire logic [11:0] code,
  input wire logic [3:0] lat,
  output logic convDone,
  output logic [11:0] convCode,
  output logic auxDone
);
  int n = 0;
  int m = 0;
  initial {convDone, auxDone, convCode} = 14'h0000;
  // code valid only with done, inverted otherwise
  always @(posedge clk) begin
    convDone <= (n == 1);
    auxDone <= (m == 1);
    convCode <= (n == 1) ? code : ~convCode;
    n <= convStart ? lat + 1 : (n > 0 ? n - 1 : 0);
    m <= auxStart ? lat + 1 : (m > 0 ? m - 1 : 0);
  end
endmodule // rsd_conv_model

// file: tb/tb_top.sv
// self-checking bench for the reference self-check block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, reset_n = 0, selfCheckEnable = 0, auxEnable = 0, scanStart = 0, cellsDone = 0;
  logic refPinHigh = 0, alertClear = 0, convStart, useThermistorScale, auxStart, scanBusy;
  logic referenceOpenAlert, convDone, auxDone;
  logic [11:0] convCode, code = 12'h000;
  logic [15:0] selfCheckResult, faultAnalysisReg, expRes = 16'h0000;
  logic [3:0] lat = 4'h0;
  int fails = 0, checksDone = 0, nConv = 0, nAux = 0, expConv = 0, expAux = 0;
  logic [11:0] codes [11] = '{12'h5E1, 12'h54B, 12'h677, 12'h1DA, 12'h1DC, 12'h292, 12'h293,
    12'h3C1, 12'h7AE, 12'h000, 12'hFFF};
  int cls [11] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 3};
  int base = 0;
  // host sorting of a self-check code; an open reference is left to the alert
  function automatic int classify(input logic [11:0] v);
    if (v >= 12'h54B && v <= 12'h677) return 0;
    if (v >= 12'h1DA && v <= 12'h1DC) return 1;
    if (v >= 12'h292 && v <= 12'h293) return 2;
    return 3;
  endfunction
  // host drift test against the first stored code
  function automatic bit drift_ok(input int v, input int b);
    return (v - b <= 4) && (b - v <= 4);
  endfunction
  initial forever #25 clk = ~clk;
  // count start pulses
  always @(posedge clk) begin
    if (convStart === 1'b1) nConv++;
    if (auxStart === 1'b1) nAux++;
  end
  rsd_self_check u_dut (.clk, .reset_n, .selfCheckEnable, .auxEnable, .scanStart, .cellsDone, .convDone,
    .convCode, .auxDone, .refPinHigh, .alertClear, .convStart, .useThermistorScale, .auxStart, .scanBusy,
    .selfCheckResult, .faultAnalysisReg, .referenceOpenAlert);
  rsd_conv_model u_conv (.clk, .convStart, .auxStart, .code, .lat, .convDone, .convCode, .auxDone);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one scan: cells, optional self-check, optional aux
  task automatic scan(input logic e, input logic a, input logic [11:0] c);
    int i;
    @(posedge clk);
    {selfCheckEnable, auxEnable, code, lat} <= {e, a, c, 4'($urandom_range(0, 9))};
    scanStart <= 1'b1;
    @(posedge clk) scanStart <= 1'b0;
    repeat (3) @(posedge clk);
    cellsDone <= 1'b1;
    @(posedge clk) cellsDone <= 1'b0;
    for (i = 0; i < 40 && scanBusy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40) begin
      fails++;
      end_of_test();
    end
    if (e) expRes = {c, 4'h0};
    expConv += e;
    expAux += a;
    chk(selfCheckResult, expRes);
    chk(16'(nConv), 16'(expConv));
    chk(16'(nAux), 16'(expAux));
  endtask
  initial begin
    void'($urandom(32'h9B0E));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(faultAnalysisReg, 16'h0000);
    chk(selfCheckResult, 16'h0000);
    for (int k = 0; k < 22; k++) begin
      scan(k < 11 || k % 3 != 1, k < 11 ? 1'($urandom) : 1'(k % 2), k < 11 ? codes[k] : 12'($urandom));
      if (k < 11) chk(16'(classify(selfCheckResult[15:4])), 16'(cls[k]));
      if (k == 0) base = selfCheckResult[15:4];
    end
    // host drift test against the stored baseline
    scan(1'b1, 1'b0, 12'h5E5);
    chk(16'(drift_ok(selfCheckResult[15:4], base)), 16'h0001);
    scan(1'b1, 1'b0, 12'h5DC);
    chk(16'(drift_ok(selfCheckResult[15:4], base)), 16'h0000);
    // slow level changes, one per detector window, must not alert
    repeat (2) begin
      @(posedge clk) refPinHigh <= ~refPinHigh;
      repeat (300) @(posedge clk);
    end
    #1;
    chk(faultAnalysisReg, 16'h0000);
    // oscillate the reference pin
    repeat (8) begin
      @(posedge clk) refPinHigh <= ~refPinHigh;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    #1;
    chk(faultAnalysisReg, 16'h0001);
    repeat (260) @(posedge clk) alertClear <= 1'b1;
    @(posedge clk) alertClear <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, referenceOpenAlert}, 16'h0000);
    end_of_test();
  end
endmodule // tb_top
bind rsd_self_check rsd_self_check_asserts u_chk (.clk, .reset_n, .selfCheckEnable, .auxEnable, .cellsDone,
  .convDone, .convCode, .alertClear, .convStart, .useThermistorScale, .auxStart, .selfCheckResult,
  .faultAnalysisReg, .referenceOpenAlert);
